/* File: sfcf_frontend.sv */
// Purpose: Serial slave command front end of a byte-wide nonvolatile memory.
// Assumes: Serial pins are oversampled by sys_clk_i, several times faster.
// Notes:   Memory, protection and id sub-blocks sit behind the cmd port.
//
// Functional notes
// - Sample input on rise, drive output on fall.
// - Clock level at select picks mode 0/3.
// - Mode 3 waits for first clock transition.
// - Deselected: input ignored, output tristated.
// - First byte is opcode, one per select.
// - All bytes travel most significant bit first.
// - Three address bytes, low 17 bits used.
// - Unknown opcode: ignore rest, output stays tristated.
// - Ten opcodes; status read and write codes.
// - Latch set and latch clear opcode codes.
// - Read, fast read and write opcode codes.
// - Sleep, ident and serial number opcode codes.
// - Latch clear at power-up, set by opcode.
// - Status write data never reaches the latch.
// - Latch clears at deselect after writes.
// - Latch clear opcode blocks writes, flag zero.
// - Writes finish at once, never busy.
// - Write latch flag is status bit one.
// - Status read shifts out the status byte.
// - Hold low freezes clock and select.
`timescale 1ns/1ns
`default_nettype none
module sfcf_frontend (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      sck_i,
    input  wire logic                      si_i,
    input  wire logic                      hold_n_i,
    input  wire logic [2:0]                prot_bits_i,
    input  wire logic [7:0]                tx_byte_i,
    output var  logic                      so_o,
    output var  logic                      so_oe_o,
    output var  logic                      cmd_valid_o,
    output var  sfcf_pkg::sfcf_cmd_t       cmd_o,
    output var  logic                      active_o,
    output var  logic                      addr_valid_o,
    output var  logic [16:0]               addr_o,
    output var  logic                      rx_valid_o,
    output var  logic [7:0]                rx_byte_o,
    output var  logic                      tx_req_o,
    output var  logic                      wel_o,
    output var  logic                      mode3_o
);
    localparam logic [3:0] SYNC_RST = {sfcf_pkg::RST_HOLD_N,
        sfcf_pkg::RST_SI, sfcf_pkg::RST_SCK, sfcf_pkg::RST_CS_N};

    logic [3:0]              pins_s;
    logic                    cs_s, sck_s, si_s, hold_s;
    logic                    cs_q_reg, sck_q_reg;
    sfcf_pkg::sfcf_state_t   state_reg, state_next;
    logic [2:0]              bit_cnt_reg;
    logic [1:0]              addr_cnt_reg;
    logic [23:0]             rx_sh_reg;
    logic [7:0]              tx_sh_reg;
    logic                    armed_reg, is_read_reg, tx_pend_reg;
    logic                    tx_stat_reg, clr_pend_reg;

    sfcf_op_if op ();

    sfcf_sync #(
        .WIDTH   (4),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   ({hold_n_i, si_i, sck_i, cs_n_i}),
        .sync_o    (pins_s)
    );

    sfcf_opdec u_dec (
        .op (op)
    );

    assign cs_s   = pins_s[0];
    assign sck_s  = pins_s[1];
    assign si_s   = pins_s[2];
    assign hold_s = pins_s[3];

    // Hold masks every select and clock event.
    wire logic hold_ok  = hold_s;
    wire logic cs_fall  = hold_ok & cs_q_reg & ~cs_s;
    wire logic cs_rise  = hold_ok & ~cs_q_reg & cs_s;
    wire logic selected = hold_ok & ~cs_s & ~cs_q_reg;
    wire logic sck_rise = selected & armed_reg & sck_s & ~sck_q_reg;
    wire logic sck_fall = selected & ~sck_s & sck_q_reg;
    wire logic byte_end = sck_rise & (bit_cnt_reg == 3'h7);
    wire logic [23:0] rx_next = {rx_sh_reg[22:0], si_s};

    wire logic in_op   = (state_reg == sfcf_pkg::SFCF_ST_OPCODE);
    wire logic in_addr = (state_reg == sfcf_pkg::SFCF_ST_ADDR);
    wire logic in_data = (state_reg == sfcf_pkg::SFCF_ST_DATA);
    wire logic op_done = byte_end & in_op;
    wire logic op_ok   = op_done & op.known;
    wire logic op_bad  = op_done & ~op.known;
    wire logic addr_last = byte_end & in_addr &
        (addr_cnt_reg == 2'(sfcf_pkg::ADDR_BYTES - 1));
    wire logic data_byte = byte_end & in_data;

    // Data phase starts right after the opcode or after the last address.
    wire logic data_start = (op_ok & ~op.has_addr) | addr_last;
    wire logic read_start = (data_start & ((op_ok & op.is_read) |
                            (addr_last & is_read_reg))) |
                            (data_byte & is_read_reg);
    wire logic stat_sel = op_ok ? (op.cmd ==
                          sfcf_pkg::SFCF_STATUS_READ_CMD) : tx_stat_reg;

    wire logic set_wel = op_ok &
        (op.cmd == sfcf_pkg::SFCF_LATCH_SET_CMD);
    wire logic arm_clr = op_ok &
        ((op.cmd == sfcf_pkg::SFCF_LATCH_CLEAR_CMD) |
         (op.cmd == sfcf_pkg::SFCF_STATUS_WRITE_CMD) |
         (op.cmd == sfcf_pkg::SFCF_MEM_WRITE_CMD));

    // Status byte: fixed bits, the protection inputs and the live latch; bit 0 never shows busy.
    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[sfcf_pkg::ST_WEL_BIT]  = wel_o;
        status_byte[sfcf_pkg::ST_BP0_BIT]  = prot_bits_i[0];
        status_byte[sfcf_pkg::ST_BP1_BIT]  = prot_bits_i[1];
        status_byte[sfcf_pkg::ST_ONE_BIT]  = 1'b1;
        status_byte[sfcf_pkg::ST_WPEN_BIT] = prot_bits_i[2];
    end
    wire logic [7:0] tx_src = tx_stat_reg ? status_byte : tx_byte_i;

    assign op.opcode = rx_next[7:0];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sfcf_pkg::SFCF_ST_IDLE: begin
                state_next = state_reg;
            end
            sfcf_pkg::SFCF_ST_OPCODE: begin
                if (op_bad) begin
                    state_next = sfcf_pkg::SFCF_ST_IGNORE;
                end else if (op_ok && op.has_addr) begin
                    state_next = sfcf_pkg::SFCF_ST_ADDR;
                end else if (op_ok) begin
                    state_next = sfcf_pkg::SFCF_ST_DATA;
                end
            end
            sfcf_pkg::SFCF_ST_ADDR: begin
                if (addr_last) begin
                    state_next = sfcf_pkg::SFCF_ST_DATA;
                end
            end
            sfcf_pkg::SFCF_ST_DATA: begin
                state_next = state_reg;
            end
            sfcf_pkg::SFCF_ST_IGNORE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = sfcf_pkg::SFCF_ST_IDLE;
            end
        endcase
        if (cs_rise) begin
            state_next = sfcf_pkg::SFCF_ST_IDLE;
        end else if (cs_fall) begin
            state_next = sfcf_pkg::SFCF_ST_OPCODE;
        end
    end

    // Only the select history freezes under hold, so that a release
    // with a moved clock pin does not fake an edge on the clock line.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_q_reg  <= sfcf_pkg::RST_CS_N;
            sck_q_reg <= sfcf_pkg::RST_SCK;
            state_reg <= sfcf_pkg::SFCF_ST_IDLE;
        end else begin
            cs_q_reg  <= hold_ok ? cs_s : cs_q_reg;
            sck_q_reg <= sck_s;
            state_reg <= state_next;
        end
    end

    // Mode 3 starts disarmed and arms on its first falling clock.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_reg <= 1'b0;
            mode3_o   <= 1'b0;
        end else if (cs_fall) begin
            armed_reg <= ~sck_s;
            mode3_o   <= sck_s;
        end else if (sck_fall) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 2'h0;
            rx_sh_reg    <= 24'h000000;
        end else if (cs_fall) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 2'h0;
            rx_sh_reg    <= 24'h000000;
        end else if (sck_rise) begin
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            rx_sh_reg    <= rx_next;
            addr_cnt_reg <= (byte_end & in_addr) ?
                            addr_cnt_reg + 2'h1 : addr_cnt_reg;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_o  <= 1'b0;
            cmd_o        <= sfcf_pkg::SFCF_CMD_NONE;
            active_o     <= 1'b0;
            is_read_reg  <= 1'b0;
            addr_valid_o <= 1'b0;
            addr_o       <= 17'h00000;
            rx_valid_o   <= 1'b0;
            rx_byte_o    <= 8'h00;
        end else begin
            cmd_valid_o  <= op_ok;
            cmd_o        <= op_ok ? op.cmd : cmd_o;
            active_o     <= cs_rise ? 1'b0 : (op_ok | active_o);
            is_read_reg  <= op_ok ? op.is_read : is_read_reg;
            addr_valid_o <= addr_last;
            addr_o       <= addr_last ?
                rx_next[sfcf_pkg::ADDR_USED-1:0] : addr_o;
            rx_valid_o   <= data_byte;
            rx_byte_o    <= data_byte ? rx_next[7:0] : rx_byte_o;
        end
    end

    // Read data is loaded on the falling edge after the byte boundary, so a
    // sub-block gets the time up to that edge to present tx_byte_i.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pend_reg <= 1'b0;
            tx_stat_reg <= 1'b0;
            tx_req_o    <= 1'b0;
            tx_sh_reg   <= 8'h00;
            so_o        <= 1'b0;
        end else begin
            tx_req_o    <= read_start & ~stat_sel;
            tx_stat_reg <= cs_fall ? 1'b0 : stat_sel;
            if (cs_fall) begin
                tx_pend_reg <= 1'b0;
            end else if (read_start) begin
                tx_pend_reg <= 1'b1;
            end else if (sck_fall) begin
                tx_pend_reg <= 1'b0;
            end
            if (sck_fall && tx_pend_reg) begin
                so_o      <= tx_src[7];
                tx_sh_reg <= {tx_src[6:0], 1'b0};
            end else if (sck_fall) begin
                so_o      <= tx_sh_reg[7];
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // Output drives only in the data phase of a read, while selected.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            so_oe_o <= 1'b0;
        end else begin
            so_oe_o <= selected & ~cs_rise & in_data & is_read_reg &
                       (tx_pend_reg | (bit_cnt_reg != 3'h0) |
                        so_oe_o);
        end
    end

    // Latch: set by its opcode, cleared at deselect after a write command.
    // The incoming status byte is never routed here.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_o        <= sfcf_pkg::RST_WEL;
            clr_pend_reg <= 1'b0;
        end else begin
            clr_pend_reg <= cs_fall ? 1'b0 : (arm_clr | clr_pend_reg);
            if (set_wel) begin
                wel_o <= 1'b1;
            end else if (cs_rise && clr_pend_reg) begin
                wel_o <= 1'b0;
            end
        end
    end

    logic [1:0] ops_seen_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ops_seen_reg <= 2'h0;
        end else if (cs_fall) begin
            ops_seen_reg <= 2'h0;
        end else if (cmd_valid_o && ops_seen_reg != 2'h3) begin
            ops_seen_reg <= ops_seen_reg + 2'h1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_SO_ON_FALL: assert property (
        $changed(so_o) |-> $past(sck_fall))
        else $error("serial output changed without a falling clock");
    AST_MODE_PICK: assert property (
        cs_fall |=> (mode3_o == $past(sck_s)) && (armed_reg == !mode3_o))
        else $error("clock mode not taken from clock level at select");
    AST_MODE3_WAIT: assert property (
        selected && !armed_reg |=> $stable(bit_cnt_reg) &&
        $stable(rx_sh_reg))
        else $error("mode 3 sampled before the first clock transition");
    AST_DESEL_TRI: assert property (
        cs_rise |=> !so_oe_o [*2])
        else $error("serial output driven after deselect");
    AST_ONE_OPCODE: assert property (
        ops_seen_reg <= 2'h1)
        else $error("more than one opcode in one select period");
    AST_BAD_OP: assert property (
        op_bad |=> (state_reg == sfcf_pkg::SFCF_ST_IGNORE) && !so_oe_o &&
        !cmd_valid_o)
        else $error("unknown opcode not ignored");
    AST_ADDR_CMD: assert property (
        addr_valid_o |-> active_o && (cmd_o == sfcf_pkg::SFCF_MEM_READ_CMD ||
        cmd_o == sfcf_pkg::SFCF_FAST_READ_CMD ||
        cmd_o == sfcf_pkg::SFCF_MEM_WRITE_CMD))
        else $error("address delivered for a command without one");
    AST_WEL_SET: assert property (
        cmd_valid_o && cmd_o == sfcf_pkg::SFCF_LATCH_SET_CMD |-> wel_o)
        else $error("latch not set by its opcode");
    AST_WEL_CLR: assert property (
        cs_rise && clr_pend_reg |=> !wel_o ##1 !wel_o)
        else $error("latch not cleared at deselect after a write");
    AST_WEL_HOLD: assert property (
        $rose(wel_o) |-> $past(set_wel))
        else $error("latch set by something other than its opcode");
    AST_STATUS_BITS: assert property (
        status_byte[sfcf_pkg::ST_WEL_BIT] == wel_o &&
        status_byte[sfcf_pkg::ST_ONE_BIT] && !status_byte[0])
        else $error("status byte does not show the latch");

    COV_MODE3: cover property (cs_fall && sck_s ##[1:200] op_ok);
    COV_BAD_OP: cover property (op_bad);
    COV_ADDR: cover property (addr_valid_o);
    COV_STATUS_READ: cover property (so_oe_o && tx_stat_reg);
endmodule : sfcf_frontend
`default_nettype wire

/* File: sfcf_master.sv */
// Purpose: Behavioural serial bus master driving the front end pins.
// Assumes: Half clock period of five system clocks.
// Notes:   Data line toggles when released so stale bits never match.
`timescale 1ns/1ns
`default_nettype none
module sfcf_master (
    input  wire logic clk_i,
    input  wire logic so_i,
    output var  logic cs_n_o,
    output var  logic sck_o,
    output var  logic si_o
);
    logic m3 = 1'b0;
    initial {cs_n_o, sck_o, si_o} = 3'b100;
    task automatic half();
        repeat (5) @(negedge clk_i);
    endtask
    task automatic sel(input logic mode3);
        m3 = mode3;
        sck_o = mode3;
        half();
        cs_n_o = 1'b0;
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            half();
            sck_o = 1'b1;
            rx[i] = so_i;
            half();
        end
    endtask
    task automatic desel();
        sck_o = m3;
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half();
        half();
    endtask
endmodule // sfcf_master
`default_nettype wire

/* File: sfcf_op_if.sv */
// Purpose: Carries a received opcode to the decoder and the decode back.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   The front end drives the opcode, the decoder answers.
`timescale 1ns/1ns
`default_nettype none
interface sfcf_op_if;
    logic [7:0]         opcode;
    sfcf_pkg::sfcf_cmd_t cmd;
    logic               known;
    logic               has_addr;
    logic               is_read;

    modport front (output opcode, input cmd, input known, input has_addr,
                   input is_read);
    modport dec   (input opcode, output cmd, output known, output has_addr,
                   output is_read);
endinterface : sfcf_op_if
`default_nettype wire

/* File: sfcf_opdec.sv */
// Purpose: Maps an opcode byte onto the command set.
// Assumes: Opcode is stable while it is read.
// Notes:   Any byte outside the ten opcodes decodes as unknown.
`timescale 1ns/1ns
`default_nettype none
module sfcf_opdec (
    sfcf_op_if.dec op
);
    wire logic [7:0] o = op.opcode;

    assign op.cmd =
        (o == sfcf_pkg::OP_LATCH_SET)    ? sfcf_pkg::SFCF_LATCH_SET_CMD    :
        (o == sfcf_pkg::OP_LATCH_CLEAR)  ? sfcf_pkg::SFCF_LATCH_CLEAR_CMD  :
        (o == sfcf_pkg::OP_STATUS_READ)  ? sfcf_pkg::SFCF_STATUS_READ_CMD  :
        (o == sfcf_pkg::OP_STATUS_WRITE) ? sfcf_pkg::SFCF_STATUS_WRITE_CMD :
        (o == sfcf_pkg::OP_MEM_READ)     ? sfcf_pkg::SFCF_MEM_READ_CMD     :
        (o == sfcf_pkg::OP_FAST_READ)    ? sfcf_pkg::SFCF_FAST_READ_CMD    :
        (o == sfcf_pkg::OP_MEM_WRITE)    ? sfcf_pkg::SFCF_MEM_WRITE_CMD    :
        (o == sfcf_pkg::OP_SLEEP)        ? sfcf_pkg::SFCF_SLEEP_CMD        :
        (o == sfcf_pkg::OP_IDENT_READ)   ? sfcf_pkg::SFCF_IDENT_READ_CMD   :
        (o == sfcf_pkg::OP_SERIAL_READ)  ?
            sfcf_pkg::SFCF_SERIAL_NUMBER_READ_CMD : sfcf_pkg::SFCF_CMD_NONE;

    assign op.known    = (op.cmd != sfcf_pkg::SFCF_CMD_NONE);
    assign op.has_addr = (op.cmd == sfcf_pkg::SFCF_MEM_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_FAST_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_MEM_WRITE_CMD);
    assign op.is_read  = (op.cmd == sfcf_pkg::SFCF_STATUS_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_MEM_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_FAST_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_IDENT_READ_CMD) ||
                         (op.cmd == sfcf_pkg::SFCF_SERIAL_NUMBER_READ_CMD);
endmodule : sfcf_opdec
`default_nettype wire

/* File: sfcf_pkg.sv */
// Purpose: Shared constants and types of the serial memory command front end.
// Assumes: One system clock; serial pins are asynchronous to it.
// Notes:   Opcode values and status bit positions are fixed by the device.
package sfcf_pkg;

    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ     = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_MEM_WRITE    = 8'h02;
    localparam logic [7:0] OP_SLEEP        = 8'hb9;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9f;
    localparam logic [7:0] OP_SERIAL_READ  = 8'hc3;

    localparam int ADDR_BYTES    = 3;
    localparam int ADDR_USED     = 17;
    localparam int ADDR_RX_BITS  = 24;
    localparam int BYTE_BITS     = 8;

    localparam int ST_WEL_BIT    = 1;
    localparam int ST_BP0_BIT    = 2;
    localparam int ST_BP1_BIT    = 3;
    localparam int ST_ONE_BIT    = 6;
    localparam int ST_WPEN_BIT   = 7;

    localparam logic RST_WEL     = 1'b0;
    localparam logic RST_CS_N    = 1'b1;
    localparam logic RST_SCK     = 1'b0;
    localparam logic RST_HOLD_N  = 1'b1;
    localparam logic RST_SI      = 1'b0;

    typedef enum logic [3:0] {
        SFCF_CMD_NONE,
        SFCF_LATCH_SET_CMD,
        SFCF_LATCH_CLEAR_CMD,
        SFCF_STATUS_READ_CMD,
        SFCF_STATUS_WRITE_CMD,
        SFCF_MEM_READ_CMD,
        SFCF_FAST_READ_CMD,
        SFCF_MEM_WRITE_CMD,
        SFCF_SLEEP_CMD,
        SFCF_IDENT_READ_CMD,
        SFCF_SERIAL_NUMBER_READ_CMD
    } sfcf_cmd_t;

    typedef enum logic [2:0] {
        SFCF_ST_IDLE   = 3'b000,
        SFCF_ST_OPCODE = 3'b001,
        SFCF_ST_ADDR   = 3'b011,
        SFCF_ST_DATA   = 3'b010,
        SFCF_ST_IGNORE = 3'b110
    } sfcf_state_t;

endpackage : sfcf_pkg

/* File: sfcf_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ns
`default_nettype none
module sfcf_sync #(
    parameter int               WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                meta_reg[b] <= RST_VAL[b];
                sync_o[b]   <= RST_VAL[b];
            end else begin
                meta_reg[b] <= async_i[b];
                sync_o[b]   <= meta_reg[b];
            end
        end
    end
endmodule : sfcf_sync
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench of the command front end.
// Assumes: Protection bits start at wpen=1, bp0=1, later bp1 alone.
// Notes:   Status byte reads c4h, or c6h with the latch set, at first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    wire         cs_n, sck, si, so, so_oe, cmd_valid, active;
    wire         addr_valid, rx_valid, tx_req, write_latch_flag, mode3;
    wire  [16:0] addr;
    wire  [7:0]  rx_byte;
    sfcf_pkg::sfcf_cmd_t cmd;
    logic [16:0] last_addr;
    logic [7:0]  last_rx, rx;
    logic        hold_n = 1'b1;
    logic [2:0]  prot = 3'b101;
    logic [7:0]  tx_byte = 8'h3c;
    int          err_total = 0, tests_run = 0, ncmd = 0, nreq = 0;
    logic [7:0]  tbl_w [5] = '{8'h02, 8'h01, 8'hab, 8'hcd, 8'h5a};
    logic [7:0]  tbl_b [3] = '{8'h00, 8'h05, 8'h00};
    logic [7:0]  tbl_r [4] = '{8'h03, 8'h00, 8'h01, 8'h23};
    logic [7:0]  ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b,
                              8'h02, 8'hb9, 8'h9f, 8'hc3};
    always #4 sys_clk = ~sys_clk;
    sfcf_frontend sfcf_frontend_i (.sys_clk_i(sys_clk), .rst_i(rst),
        .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n),
        .prot_bits_i(prot), .tx_byte_i(tx_byte), .so_o(so), .so_oe_o(so_oe),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .active_o(active),
        .addr_valid_o(addr_valid), .addr_o(addr), .rx_valid_o(rx_valid),
        .rx_byte_o(rx_byte), .tx_req_o(tx_req), .wel_o(write_latch_flag), .mode3_o(mode3));
    sfcf_master sfcf_master_i (.clk_i(sys_clk), .so_i(so_oe ? so : 1'bz),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1) ncmd++;
        if (tx_req === 1'b1) nreq++;
        if (addr_valid === 1'b1) last_addr = addr;
        if (rx_valid === 1'b1) last_rx = rx_byte;
    end
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic one(input logic [7:0] op, input logic m3);
        sfcf_master_i.sel(m3);
        sfcf_master_i.xfer(op, rx);
        sfcf_master_i.desel();
    endtask
    task automatic status(input logic [7:0] exp);
        sfcf_master_i.sel(1'b0);
        sfcf_master_i.xfer(8'h05, rx);
        sfcf_master_i.xfer(8'h00, rx);
        check(rx, exp);
        sfcf_master_i.desel();
        check(so_oe, 1'b0);
    endtask
    task automatic t_latch();
        check(write_latch_flag, 1'b0);
        status(8'hc4);
        one(8'h06, 1'b1);
        check(mode3, 1'b1);
        check(write_latch_flag, 1'b1);
        status(8'hc6);
        check(mode3, 1'b0);
        one(8'h04, 1'b1);
        check(write_latch_flag, 1'b0);
        $display("latch test done");
    endtask
    task automatic t_writes();
        one(8'h06, 1'b0);
        sfcf_master_i.sel(1'b0);
        sfcf_master_i.xfer(8'h01, rx);
        sfcf_master_i.xfer(8'h00, rx);
        check(write_latch_flag, 1'b1);
        sfcf_master_i.desel();
        check(write_latch_flag, 1'b0);
        one(8'h06, 1'b0);
        sfcf_master_i.sel(1'b1);
        foreach (tbl_w[i]) sfcf_master_i.xfer(tbl_w[i], rx);
        check(last_addr, 17'h1abcd);
        check(last_rx, 8'h5a);
        sfcf_master_i.desel();
        check(write_latch_flag, 1'b0);
        status(8'hc4);
        $display("write test done");
    endtask
    task automatic t_bad();
        int n = ncmd;
        sfcf_master_i.sel(1'b0);
        foreach (tbl_b[i]) sfcf_master_i.xfer(tbl_b[i], rx);
        check(so_oe, 1'b0);
        sfcf_master_i.desel();
        check(17'(ncmd), 17'(n));
        sfcf_master_i.sel(1'b0);
        sfcf_master_i.xfer(8'h06, rx);
        sfcf_master_i.xfer(8'h04, rx);
        sfcf_master_i.desel();
        check(write_latch_flag, 1'b1);
        one(8'h04, 1'b0);
        $display("refusal test done");
    endtask
    task automatic t_ops();
        for (int i = 0; i < 10; i++) begin
            one(ops[i], 1'b0);
            check(cmd, 17'(i + 1));
        end
        $display("opcode test done");
    endtask
    // A read hands out the sub-block byte; a held first byte must vanish.
    task automatic t_read();
        int n = nreq;
        tx_byte = 8'h96;
        prot = 3'b010;
        sfcf_master_i.sel(1'b0);
        foreach (tbl_r[i]) sfcf_master_i.xfer(tbl_r[i], rx);
        check(active, 1'b1);
        sfcf_master_i.xfer(8'h00, rx);
        check(rx, 8'h96);
        check(17'(nreq - n), 17'h2);
        check(last_addr, 17'h00123);
        sfcf_master_i.desel();
        check(active, 1'b0);
        sfcf_master_i.sel(1'b0);
        hold_n = 1'b0;
        sfcf_master_i.xfer(8'h00, rx);
        hold_n = 1'b1;
        sfcf_master_i.xfer(8'h06, rx);
        sfcf_master_i.desel();
        check(write_latch_flag, 1'b1);
        status(8'h4a);
        one(8'h04, 1'b0);
        $display("read and hold test done");
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_latch();
        t_writes();
        t_bad();
        t_ops();
        t_read();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
